// *** include/scc_pkg.sv ***
package scc_pkg;

	// ------------------------------------------------------------
	// register map (printed offsets are indices; byte address = 4 * index)
	// ------------------------------------------------------------
	localparam int NREG = 10;
	localparam int IW = 10;
	localparam logic [IW-1:0] IDX_CLOCKGEN_SETUP = 10'h020;
	localparam logic [IW-1:0] IDX_LOGIC_GLOBAL_SETUP = 10'h022;
	localparam logic [IW-1:0] IDX_PIXEL_ARRAY_POWER = 10'h028;
	localparam logic [IW-1:0] IDX_PIXEL_ARRAY_SLOPE_LEVELS = 10'h029;
	localparam logic [IW-1:0] IDX_FRONTEND_POWER = 10'h030;
	localparam logic [IW-1:0] IDX_BANDGAP_POWER = 10'h040;
	localparam logic [IW-1:0] IDX_BIAS_CURRENT_SETUP = 10'h041;
	localparam logic [IW-1:0] IDX_FRONTEND_CURRENT_SETUP = 10'h042;
	localparam logic [IW-1:0] IDX_COLUMN_SELECT_CURRENT = 10'h043;
	localparam logic [IW-1:0] IDX_SERIAL_OUTPUT_CURRENT = 10'h044;

	localparam logic [15:0] RST_CLOCKGEN_SETUP = 16'h0004;
	localparam logic [15:0] RST_LOGIC_GLOBAL_SETUP = 16'h0000;
	localparam logic [15:0] RST_PIXEL_ARRAY_POWER = 16'h0000;
	localparam logic [15:0] RST_PIXEL_ARRAY_SLOPE_LEVELS = 16'h0b5a;
	localparam logic [15:0] RST_FRONTEND_POWER = 16'h0000;
	localparam logic [15:0] RST_BANDGAP_POWER = 16'h0000;
	localparam logic [15:0] RST_BIAS_CURRENT_SETUP = 16'h888b;
	localparam logic [15:0] RST_FRONTEND_CURRENT_SETUP = 16'h53c8;
	localparam logic [15:0] RST_COLUMN_SELECT_CURRENT = 16'h8888;
	localparam logic [15:0] RST_SERIAL_OUTPUT_CURRENT = 16'h0088;

	// slot order of the storage array
	localparam int S_CLK = 0;
	localparam int S_LOG = 1;
	localparam int S_PWR = 2;
	localparam int S_SLP = 3;
	localparam int S_AFE = 4;
	localparam int S_BG = 5;
	localparam int S_BIAS = 6;
	localparam int S_FEC = 7;
	localparam int S_CSEL = 8;
	localparam int S_SER = 9;

	localparam logic [IW-1:0] REG_IDX [NREG] = '{IDX_CLOCKGEN_SETUP,
		IDX_LOGIC_GLOBAL_SETUP, IDX_PIXEL_ARRAY_POWER, IDX_PIXEL_ARRAY_SLOPE_LEVELS,
		IDX_FRONTEND_POWER, IDX_BANDGAP_POWER, IDX_BIAS_CURRENT_SETUP,
		IDX_FRONTEND_CURRENT_SETUP, IDX_COLUMN_SELECT_CURRENT,
		IDX_SERIAL_OUTPUT_CURRENT};
	localparam logic [15:0] REG_RST [NREG] = '{RST_CLOCKGEN_SETUP,
		RST_LOGIC_GLOBAL_SETUP, RST_PIXEL_ARRAY_POWER, RST_PIXEL_ARRAY_SLOPE_LEVELS,
		RST_FRONTEND_POWER, RST_BANDGAP_POWER, RST_BIAS_CURRENT_SETUP,
		RST_FRONTEND_CURRENT_SETUP, RST_COLUMN_SELECT_CURRENT,
		RST_SERIAL_OUTPUT_CURRENT};

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int B_ANALOG_CLK = 0;
	localparam int B_LOGIC_CLK = 1;
	localparam int B_PLL_SEL = 2;
	localparam int B_ADC_8BIT = 3;
	localparam int B_LOGIC_EN = 0;
	localparam int B_CORE_PWR = 0;
	localparam int B_COLMUX_PWR = 1;
	localparam int B_COLBIAS_EN = 2;
	localparam int B_PWR_UP = 0;
	localparam int B_EXT_RES = 0;
	localparam int L_NIB0 = 0;
	localparam int L_NIB1 = 4;
	localparam int L_NIB2 = 8;
	localparam int L_NIB3 = 12;
	localparam int L_PGA = 8;
	localparam int NCOL = 8;

	typedef struct packed {
		logic analog_clk_en;
		logic logic_clk_en;
		logic pll_clk_sel;
		logic adc_8bit;
		logic logic_en;
		logic core_pwr_up;
		logic colmux_pwr_up;
		logic colbias_en;
		logic [3:0] double_slope_level;
		logic [3:0] triple_slope_level;
		logic [NCOL-1:0] frontend_pwr_up;
		logic bandgap_pwr_up;
		logic ext_res_sel;
		logic [3:0] precharge_current;
		logic [3:0] column_bias_current;
		logic [3:0] pump_current;
		logic [3:0] frontend_current;
		logic [3:0] adc_ref_current;
		logic [6:0] pga_ref_current;
		logic [3:0] column_select_first_current;
		logic [3:0] column_select_second_current;
		logic [3:0] serial_bias_current;
		logic [3:0] serial_ref_current;
	} scc_cfg_t;

endpackage

// *** logic/scc_regs.sv ***
// How it works
// - bit 0 at 32 gates analog clocks
// - bit 1 at 32 gates logic clock
// - bit 2 at 32 picks PLL, resets 1
// - bit 3 at 32 selects 8-bit conversion
// - bit 0 at 34 enables global logic
// - bit 0 at 40 powers image core up
// - bit 1 at 40 powers column mux up
// - bit 2 at 40 enables column bias
// - register 41 holds two slope reset levels
// - bit 0 at 48 powers all eight channels
// - bit 0 at 64 powers the bandgap
// - register 65 holds three current nibbles
// - register 67 holds two column-select currents
`timescale 1ns/100ps
`default_nettype none
module scc_regs (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output scc_pkg::scc_cfg_t cfg
);
	import scc_pkg::*;

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	logic [IW-1:0] widx;
	logic [NREG-1:0] hit;
	logic mapped;
	logic wr_acc;
	logic rd_setup;
	logic [15:0] rd_mux;
	logic [15:0] prdata_q;
	logic [15:0] regs_q [NREG];

	assign widx = paddr[11:2];
	assign mapped = |hit;
	// zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wr_acc = psel && penable && pwrite && mapped;
	assign rd_setup = psel && !penable && !pwrite;
	assign prdata = {16'h0000, prdata_q};

	// ------------------------------------------------------------
	// storage, one word per entry
	// ------------------------------------------------------------
	for (genvar g = 0; g < NREG; g++) begin : g_reg
		assign hit[g] = widx == REG_IDX[g];
		// all 16 bits are kept; reserved fields rely on the host writing defaults
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				regs_q[g] <= REG_RST[g];
			end else if (wr_acc && hit[g]) begin
				if (pstrb[0]) begin
					regs_q[g][7:0] <= pwdata[7:0];
				end
				if (pstrb[1]) begin
					regs_q[g][15:8] <= pwdata[15:8];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	always_comb begin
		rd_mux = 16'h0000;
		for (int i = 0; i < NREG; i++) begin
			if (hit[i]) begin
				rd_mux = rd_mux | regs_q[i];
			end
		end
	end

	// captured in setup so the word is stable through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 16'h0000;
		end else if (rd_setup) begin
			prdata_q <= rd_mux;
		end
	end

	// ------------------------------------------------------------
	// control outputs
	// ------------------------------------------------------------
	assign cfg.analog_clk_en = regs_q[S_CLK][B_ANALOG_CLK];
	assign cfg.logic_clk_en = regs_q[S_CLK][B_LOGIC_CLK];
	assign cfg.pll_clk_sel = regs_q[S_CLK][B_PLL_SEL];
	assign cfg.adc_8bit = regs_q[S_CLK][B_ADC_8BIT];
	assign cfg.logic_en = regs_q[S_LOG][B_LOGIC_EN];
	assign cfg.core_pwr_up = regs_q[S_PWR][B_CORE_PWR];
	assign cfg.colmux_pwr_up = regs_q[S_PWR][B_COLMUX_PWR];
	assign cfg.colbias_en = regs_q[S_PWR][B_COLBIAS_EN];
	assign cfg.double_slope_level = regs_q[S_SLP][L_NIB0 +: 4];
	assign cfg.triple_slope_level = regs_q[S_SLP][L_NIB1 +: 4];
	// one control bit fans out to every channel
	for (genvar c = 0; c < NCOL; c++) begin : g_col
		assign cfg.frontend_pwr_up[c] = regs_q[S_AFE][B_PWR_UP];
	end
	assign cfg.bandgap_pwr_up = regs_q[S_BG][B_PWR_UP];
	assign cfg.ext_res_sel = regs_q[S_BIAS][B_EXT_RES];
	assign cfg.precharge_current = regs_q[S_BIAS][L_NIB1 +: 4];
	assign cfg.column_bias_current = regs_q[S_BIAS][L_NIB2 +: 4];
	assign cfg.pump_current = regs_q[S_BIAS][L_NIB3 +: 4];
	assign cfg.frontend_current = regs_q[S_FEC][L_NIB0 +: 4];
	assign cfg.adc_ref_current = regs_q[S_FEC][L_NIB1 +: 4];
	assign cfg.pga_ref_current = regs_q[S_FEC][L_PGA +: 7];
	assign cfg.column_select_first_current = regs_q[S_CSEL][L_NIB0 +: 4];
	assign cfg.column_select_second_current = regs_q[S_CSEL][L_NIB1 +: 4];
	assign cfg.serial_bias_current = regs_q[S_SER][L_NIB0 +: 4];
	assign cfg.serial_ref_current = regs_q[S_SER][L_NIB1 +: 4];

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_wr(logic [IW-1:0] a, int lane);
		psel && !penable && pwrite && widx == a && pstrb[lane] ##1 psel && penable;
	endsequence

	property p_analog_clk;
		s_wr(IDX_CLOCKGEN_SETUP, 0) |=> cfg.analog_clk_en == $past(pwdata[0]);
	endproperty
	a_analog_clk: assert property (p_analog_clk) else $error("analog clock gate wrong");

	property p_logic_clk;
		s_wr(IDX_CLOCKGEN_SETUP, 0) |=> cfg.logic_clk_en == $past(pwdata[1]);
	endproperty
	a_logic_clk: assert property (p_logic_clk) else $error("logic clock gate wrong");

	property p_pll_wr;
		s_wr(IDX_CLOCKGEN_SETUP, 0) |=> cfg.pll_clk_sel == $past(pwdata[2]);
	endproperty
	a_pll_wr: assert property (p_pll_wr) else $error("clock source select wrong");

	property p_adc_mode;
		s_wr(IDX_CLOCKGEN_SETUP, 0) |=> cfg.adc_8bit == $past(pwdata[3]);
	endproperty
	a_adc_mode: assert property (p_adc_mode) else $error("resolution select wrong");

	property p_logic_en;
		s_wr(IDX_LOGIC_GLOBAL_SETUP, 0) |=> cfg.logic_en == $past(pwdata[0]);
	endproperty
	a_logic_en: assert property (p_logic_en) else $error("logic enable wrong");

	property p_core_pwr;
		s_wr(IDX_PIXEL_ARRAY_POWER, 0) |=> cfg.core_pwr_up == $past(pwdata[0])
			&& cfg.colmux_pwr_up == $past(pwdata[1]);
	endproperty
	a_core_pwr: assert property (p_core_pwr) else $error("core or mux power wrong");

	property p_colbias;
		s_wr(IDX_PIXEL_ARRAY_POWER, 0) |=> cfg.colbias_en == $past(pwdata[2]);
	endproperty
	a_colbias: assert property (p_colbias) else $error("column bias enable wrong");

	property p_slope;
		s_wr(IDX_PIXEL_ARRAY_SLOPE_LEVELS, 0) |=>
			{cfg.triple_slope_level, cfg.double_slope_level} == $past(pwdata[7:0]);
	endproperty
	a_slope: assert property (p_slope) else $error("slope levels wrong");

	property p_frontend;
		s_wr(IDX_FRONTEND_POWER, 0) |=>
			cfg.frontend_pwr_up == {NCOL{$past(pwdata[0])}};
	endproperty
	a_frontend: assert property (p_frontend) else $error("channel power wrong");

	property p_bandgap;
		s_wr(IDX_BANDGAP_POWER, 0) |=> cfg.bandgap_pwr_up == $past(pwdata[0]);
	endproperty
	a_bandgap: assert property (p_bandgap) else $error("bandgap power wrong");

	property p_bias;
		s_wr(IDX_BIAS_CURRENT_SETUP, 1) |=> {cfg.pump_current,
			cfg.column_bias_current} == $past(pwdata[15:8]);
	endproperty
	a_bias: assert property (p_bias) else $error("bias currents wrong");

	property p_colsel;
		s_wr(IDX_COLUMN_SELECT_CURRENT, 0) |=> {cfg.column_select_second_current,
			cfg.column_select_first_current} == $past(pwdata[7:0]);
	endproperty
	a_colsel: assert property (p_colsel) else $error("column select currents wrong");

	property p_read;
		psel && !penable && !pwrite ##1 psel && penable |-> prdata[15:0] == $past(rd_mux);
	endproperty
	a_read: assert property (p_read) else $error("read data wrong");

	// ------------------------------------------------------------
	// reset values, hold and read-back checks
	// ------------------------------------------------------------
	sequence s_rd(logic [IW-1:0] a);
		psel && !penable && !pwrite && widx == a ##1 psel && penable;
	endsequence

	// first sampled edge after release still shows the defaults
	property p_pll_rst;
		$rose(presetn) |-> cfg.pll_clk_sel;
	endproperty
	a_pll_rst: assert property (p_pll_rst) else $error("clock source default wrong");

	property p_rst_clk;
		$rose(presetn) |-> regs_q[S_CLK] == RST_CLOCKGEN_SETUP;
	endproperty
	a_rst_clk: assert property (p_rst_clk) else $error("clock setup default wrong");

	property p_rst_log;
		$rose(presetn) |-> regs_q[S_LOG] == RST_LOGIC_GLOBAL_SETUP;
	endproperty
	a_rst_log: assert property (p_rst_log) else $error("logic setup default wrong");

	property p_rst_pwr;
		$rose(presetn) |-> regs_q[S_PWR] == RST_PIXEL_ARRAY_POWER;
	endproperty
	a_rst_pwr: assert property (p_rst_pwr) else $error("core power default wrong");

	property p_rst_slp;
		$rose(presetn) |-> regs_q[S_SLP] == RST_PIXEL_ARRAY_SLOPE_LEVELS;
	endproperty
	a_rst_slp: assert property (p_rst_slp) else $error("slope default wrong");

	property p_rst_afe;
		$rose(presetn) |-> regs_q[S_AFE] == RST_FRONTEND_POWER;
	endproperty
	a_rst_afe: assert property (p_rst_afe) else $error("channel power default wrong");

	property p_rst_bg;
		$rose(presetn) |-> regs_q[S_BG] == RST_BANDGAP_POWER;
	endproperty
	a_rst_bg: assert property (p_rst_bg) else $error("bandgap default wrong");

	property p_rst_bias;
		$rose(presetn) |-> regs_q[S_BIAS] == RST_BIAS_CURRENT_SETUP;
	endproperty
	a_rst_bias: assert property (p_rst_bias) else $error("bias default wrong");

	property p_rst_fec;
		$rose(presetn) |-> regs_q[S_FEC] == RST_FRONTEND_CURRENT_SETUP;
	endproperty
	a_rst_fec: assert property (p_rst_fec) else $error("frontend current default wrong");

	property p_rst_csel;
		$rose(presetn) |-> regs_q[S_CSEL] == RST_COLUMN_SELECT_CURRENT;
	endproperty
	a_rst_csel: assert property (p_rst_csel) else $error("column select default wrong");

	property p_rst_ser;
		$rose(presetn) |-> regs_q[S_SER] == RST_SERIAL_OUTPUT_CURRENT;
	endproperty
	a_rst_ser: assert property (p_rst_ser) else $error("serial current default wrong");

	// a word moves only when its own write lands
	property p_hold_clk;
		!(wr_acc && hit[S_CLK]) |=> $stable(regs_q[S_CLK]);
	endproperty
	a_hold_clk: assert property (p_hold_clk) else $error("clock setup moved");

	property p_hold_log;
		!(wr_acc && hit[S_LOG]) |=> $stable(regs_q[S_LOG]);
	endproperty
	a_hold_log: assert property (p_hold_log) else $error("logic setup moved");

	property p_hold_pwr;
		!(wr_acc && hit[S_PWR]) |=> $stable(regs_q[S_PWR]);
	endproperty
	a_hold_pwr: assert property (p_hold_pwr) else $error("core power moved");

	property p_hold_slp;
		!(wr_acc && hit[S_SLP]) |=> $stable(regs_q[S_SLP]);
	endproperty
	a_hold_slp: assert property (p_hold_slp) else $error("slope levels moved");

	property p_hold_afe;
		!(wr_acc && hit[S_AFE]) |=> $stable(regs_q[S_AFE]);
	endproperty
	a_hold_afe: assert property (p_hold_afe) else $error("channel power moved");

	property p_hold_bg;
		!(wr_acc && hit[S_BG]) |=> $stable(regs_q[S_BG]);
	endproperty
	a_hold_bg: assert property (p_hold_bg) else $error("bandgap power moved");

	property p_hold_bias;
		!(wr_acc && hit[S_BIAS]) |=> $stable(regs_q[S_BIAS]);
	endproperty
	a_hold_bias: assert property (p_hold_bias) else $error("bias currents moved");

	property p_hold_fec;
		!(wr_acc && hit[S_FEC]) |=> $stable(regs_q[S_FEC]);
	endproperty
	a_hold_fec: assert property (p_hold_fec) else $error("frontend currents moved");

	property p_hold_csel;
		!(wr_acc && hit[S_CSEL]) |=> $stable(regs_q[S_CSEL]);
	endproperty
	a_hold_csel: assert property (p_hold_csel) else $error("column select moved");

	property p_hold_ser;
		!(wr_acc && hit[S_SER]) |=> $stable(regs_q[S_SER]);
	endproperty
	a_hold_ser: assert property (p_hold_ser) else $error("serial currents moved");

	property p_extres;
		s_wr(IDX_BIAS_CURRENT_SETUP, 0) |=> cfg.ext_res_sel == $past(pwdata[0])
			&& cfg.precharge_current == $past(pwdata[7:4]);
	endproperty
	a_extres: assert property (p_extres) else $error("resistor or precharge wrong");

	property p_fec_low;
		s_wr(IDX_FRONTEND_CURRENT_SETUP, 0) |=>
			{cfg.adc_ref_current, cfg.frontend_current} == $past(pwdata[7:0]);
	endproperty
	a_fec_low: assert property (p_fec_low) else $error("frontend currents wrong");

	property p_fec_pga;
		s_wr(IDX_FRONTEND_CURRENT_SETUP, 1) |=> cfg.pga_ref_current == $past(pwdata[14:8]);
	endproperty
	a_fec_pga: assert property (p_fec_pga) else $error("amplifier reference wrong");

	property p_ser;
		s_wr(IDX_SERIAL_OUTPUT_CURRENT, 0) |=>
			{cfg.serial_ref_current, cfg.serial_bias_current} == $past(pwdata[7:0]);
	endproperty
	a_ser: assert property (p_ser) else $error("serial currents wrong");

	// a bias register write with the low lane off must leave its low byte alone
	property p_lane0_keep;
		wr_acc && hit[S_BIAS] && !pstrb[0] |=> $stable(regs_q[S_BIAS][7:0]);
	endproperty
	a_lane0_keep: assert property (p_lane0_keep) else $error("masked lane written");

	property p_unmapped_rd;
		psel && !penable && !pwrite && !mapped ##1 psel && penable |-> prdata == 32'h0;
	endproperty
	a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

	property p_rd_hold;
		psel && penable && !pwrite |=> $stable(prdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved after access");

	property p_slverr_ok;
		psel && penable && mapped |-> !pslverr;
	endproperty
	a_slverr_ok: assert property (p_slverr_ok) else $error("error on mapped access");

	property p_clk_rd;
		s_rd(IDX_CLOCKGEN_SETUP) |-> prdata[3:0] == $past({cfg.adc_8bit,
			cfg.pll_clk_sel, cfg.logic_clk_en, cfg.analog_clk_en});
	endproperty
	a_clk_rd: assert property (p_clk_rd) else $error("clock setup read wrong");

	property p_slope_rd;
		s_rd(IDX_PIXEL_ARRAY_SLOPE_LEVELS) |->
			prdata[7:0] == $past({cfg.triple_slope_level, cfg.double_slope_level});
	endproperty
	a_slope_rd: assert property (p_slope_rd) else $error("slope read wrong");

	property p_colsel_rd;
		s_rd(IDX_COLUMN_SELECT_CURRENT) |-> prdata[7:0] ==
			$past({cfg.column_select_second_current, cfg.column_select_first_current});
	endproperty
	a_colsel_rd: assert property (p_colsel_rd) else $error("column select read wrong");

endmodule
`default_nettype wire

// *** tb/scc_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
	import scc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	scc_cfg_t cfg;
	int errors = 0;
	int checks_done = 0;
	logic [31:0] rd;
	logic er;
	// byte address is four times the register index
	localparam logic [11:0] ADR [10] = '{12'h080, 12'h088, 12'h0a0, 12'h0a4, 12'h0c0,
		12'h100, 12'h104, 12'h108, 12'h10c, 12'h110};
	localparam logic [15:0] EXP [10] = '{16'h0004, 16'h0000, 16'h0000, 16'h0b5a,
		16'h0000, 16'h0000, 16'h888b, 16'h53c8, 16'h8888, 16'h0088};

	always #5 pclk = ~pclk;

	scc_regs scc_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cfg(cfg));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// let the write land before cfg is looked at
		@(negedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hf);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [15:0] exp);
		apb(1'b0, a, 32'h0, 4'h0);
		chk("readback", rd, {16'h0, exp});
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		for (int i = 0; i < 10; i++) rdchk(ADR[i], EXP[i]);
		chk("slope cfg", 32'({cfg.triple_slope_level, cfg.double_slope_level}), 32'h5a);
		chk("bias cfg", 32'({cfg.pump_current, cfg.column_bias_current,
			cfg.precharge_current}), 32'h888);
		chk("colsel cfg", 32'({cfg.column_select_second_current,
			cfg.column_select_first_current}), 32'h88);
		chk("clock cfg", 32'({cfg.adc_8bit, cfg.pll_clk_sel, cfg.logic_clk_en,
			cfg.analog_clk_en}), 32'h4);
		chk("power cfg", 32'({cfg.bandgap_pwr_up, cfg.frontend_pwr_up, cfg.colbias_en,
			cfg.colmux_pwr_up, cfg.core_pwr_up, cfg.logic_en}), 32'h0);
		chk("frontend cfg", 32'({cfg.pga_ref_current, cfg.adc_ref_current,
			cfg.frontend_current}), 32'h53c8);
		chk("ext res cfg", 32'(cfg.ext_res_sel), 32'h1);
		chk("serial cfg", 32'({cfg.serial_ref_current, cfg.serial_bias_current}), 32'h88);
	endtask

	task automatic t_clockgen();
		for (int i = 0; i < 5; i++) begin
			wr(12'h080, (i < 4) ? 32'(1 << i) : 32'h0);
			chk("clock cfg", 32'({cfg.adc_8bit, cfg.pll_clk_sel, cfg.logic_clk_en,
				cfg.analog_clk_en}), (i < 4) ? 32'(1 << i) : 32'h0);
		end
	endtask

	task automatic t_power();
		wr(12'h088, 32'h1);
		chk("logic enable", 32'(cfg.logic_en), 32'h1);
		for (int i = 0; i < 3; i++) begin
			wr(12'h0a0, 32'(1 << i));
			chk("core power", 32'({cfg.colbias_en, cfg.colmux_pwr_up, cfg.core_pwr_up}),
				32'(1 << i));
		end
		wr(12'h0c0, 32'h1);
		chk("frontend power", 32'(cfg.frontend_pwr_up), 32'hff);
		wr(12'h0c0, 32'h0);
		chk("frontend power", 32'(cfg.frontend_pwr_up), 32'h00);
		wr(12'h100, 32'h1);
		chk("bandgap power", 32'(cfg.bandgap_pwr_up), 32'h1);
	endtask

	task automatic t_fields();
		wr(12'h0a4, 32'h0b3c);
		chk("slope cfg", 32'({cfg.triple_slope_level, cfg.double_slope_level}), 32'h3c);
		wr(12'h104, 32'h123b);
		chk("bias cfg", 32'({cfg.pump_current, cfg.column_bias_current,
			cfg.precharge_current}), 32'h123);
		wr(12'h10c, 32'h8867);
		chk("colsel cfg", 32'({cfg.column_select_second_current,
			cfg.column_select_first_current}), 32'h67);
		// only the upper lane is enabled, low byte must survive
		apb(1'b1, 12'h104, 32'h0000abcd, 4'b0010);
		rdchk(12'h104, 16'hab3b);
		rdchk(12'h10c, 16'h8867);
	endtask

	task automatic t_unmapped();
		wr(12'h084, 32'h0000ffff);
		chk("unmapped error", 32'(er), 32'h1);
		apb(1'b0, 12'h084, 32'h0, 4'h0);
		chk("unmapped read", rd, 32'h0);
		chk("unmapped error", 32'(er), 32'h1);
		rdchk(12'h080, 16'h0000);
		rdchk(12'h088, 16'h0001);
	endtask

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_clockgen();
		t_power();
		t_fields();
		t_unmapped();
		// second reset in mid-run must bring every default back
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		test_done();
	end

	initial begin
		repeat (5000) @(posedge pclk);
		errors++;
		test_done();
	end
endmodule
`default_nettype wire
